// file: rtl/dmac_pkg.sv
package dmac_pkg;
    // Register and memory bus widths.
    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned REG_DATA_W = 16;
    localparam int unsigned MEM_ADDR_W = 16;

    // Per-channel register window: channel n occupies CH_STRIDE bytes from n * CH_STRIDE.
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] OFS_IO_ADDR = 4'h0;
    localparam logic [3:0] OFS_RAM_ADDR = 4'h4;
    localparam logic [3:0] OFS_COUNT = 4'h8;
    localparam logic [3:0] OFS_CTRL = 4'hc;

    // Global registers.
    localparam logic [7:0] OFS_TRIG_EXP = 8'h80;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h84;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h88;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h8c;

    // Field widths and masks.
    localparam int unsigned RAM_ADDR_W = 14;
    localparam int unsigned COUNT_W = 8;
    localparam int unsigned TRIG_EXP_W = 3;
    localparam int unsigned TRIG_SEL_W = TRIG_EXP_W + 2;
    localparam int unsigned NUM_TRIG = 1 << TRIG_SEL_W;
    localparam logic [15:0] IO_ADDR_MASK = 16'h03fe;

    // Channel control register bit positions.
    localparam int unsigned CTL_EN = 0;
    localparam int unsigned CTL_SIZE16 = 1;
    localparam int unsigned CTL_ADDR_FIX = 2;
    localparam int unsigned CTL_TTYP_LO = 3;
    localparam int unsigned CTL_TTYP_HI = 4;
    localparam int unsigned CTL_RAM_TO_IO = 5;
    localparam int unsigned CTL_TC = 7;
    localparam logic [7:0] CTL_WR_MASK = 8'h3f;

    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [TRIG_EXP_W-1:0] TRIG_EXP_RST = 3'h0;

    // Access lengths in clock cycles.
    localparam logic [1:0] RAM_ACC_CYC = 2'h1;
    localparam logic [1:0] IO_ACC_CYC = 2'h3;

    // Address and count steps.
    localparam logic [1:0] STEP_BYTE = 2'h1;
    localparam logic [1:0] STEP_HALF = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b011,
        ST_DONE = 3'b100
    } dmac_state_e;
endpackage : dmac_pkg

// file: rtl/dmac_chan_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dmac_chan_if;
    import dmac_pkg::*;
    logic wr_io;
    logic wr_ram;
    logic wr_cnt;
    logic wr_ctl;
    logic [REG_DATA_W-1:0] wdata;
    logic trig;
    logic done;
    logic pending;
    logic [7:0] ctl;
    logic [REG_DATA_W-1:0] io_addr;
    logic [RAM_ADDR_W-1:0] ram_addr;
    logic [COUNT_W-1:0] count;
    logic tc;

    modport ctrl (output wr_io, wr_ram, wr_cnt, wr_ctl, wdata, trig, done,
                  input pending, ctl, io_addr, ram_addr, count, tc);
    modport chan (input wr_io, wr_ram, wr_cnt, wr_ctl, wdata, trig, done,
                  output pending, ctl, io_addr, ram_addr, count, tc);
endinterface : dmac_chan_if
`default_nettype wire

// file: rtl/dmac_chan.sv
`timescale 1ns/10ps
`default_nettype none
module dmac_chan (
    input wire logic clk_sys,
    input wire logic resetn,
    dmac_chan_if.chan cif
);
    import dmac_pkg::*;

    logic [7:0] ctl_reg;
    logic tc_reg;
    logic pending_reg;
    logic [REG_DATA_W-1:0] io_addr_reg;
    logic [RAM_ADDR_W-1:0] ram_addr_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [1:0] step;
    logic [COUNT_W:0] count_dec;
    logic borrow;

    // One transfer moves one byte or one halfword.
    assign step = ctl_reg[CTL_SIZE16] ? STEP_HALF : STEP_BYTE;
    assign count_dec = {1'b0, count_reg} - {{(COUNT_W - 1){1'b0}}, step};
    assign borrow = count_dec[COUNT_W];

    // Pending start factor; a new trigger in the finishing cycle survives.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pending_reg <= 1'b0;
        end else if (cif.trig && ctl_reg[CTL_EN]) begin
            pending_reg <= 1'b1;
        end else if (cif.done) begin
            pending_reg <= 1'b0;
        end
    end

    // Control bits; the enable drops by itself once the count borrows.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctl_reg <= CTRL_RST;
        end else if (cif.done && borrow) begin
            ctl_reg[CTL_EN] <= 1'b0;
        end else if (cif.wr_ctl) begin
            ctl_reg <= cif.wdata[7:0] & CTL_WR_MASK;
        end
    end

    // Terminal count: set at the borrow, cleared by any control write, set wins.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tc_reg <= 1'b0;
        end else if (cif.done && borrow) begin
            tc_reg <= 1'b1;
        end else if (cif.wr_ctl) begin
            tc_reg <= 1'b0;
        end
    end

    // Addresses; the RAM address advances by the unit size unless held fixed.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            io_addr_reg <= '0;
            ram_addr_reg <= '0;
        end else begin
            if (cif.wr_io) begin
                io_addr_reg <= cif.wdata & IO_ADDR_MASK;
            end
            if (cif.wr_ram) begin
                ram_addr_reg <= cif.wdata[RAM_ADDR_W-1:0];
            end else if (cif.done && !ctl_reg[CTL_ADDR_FIX]) begin
                ram_addr_reg <= ram_addr_reg + {{(RAM_ADDR_W - 2){1'b0}}, step};
            end
        end
    end

    // Count; in halfword mode the written low bit is dropped.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
        end else if (cif.wr_cnt) begin
            count_reg <= {cif.wdata[COUNT_W-1:1], cif.wdata[0] & !ctl_reg[CTL_SIZE16]};
        end else if (cif.done) begin
            count_reg <= count_dec[COUNT_W-1:0];
        end
    end

    assign cif.pending = pending_reg;
    assign cif.ctl = {tc_reg, ctl_reg[6:0]};
    assign cif.io_addr = io_addr_reg;
    assign cif.ram_addr = ram_addr_reg;
    assign cif.count = count_reg;
    assign cif.tc = tc_reg;
endmodule : dmac_chan
`default_nettype wire

// file: rtl/dmac_top.sv
// Notes on behaviour
// - Move data between memory and peripheral registers.
// - Six channels, byte or halfword units.
// - Up to 256 byte transfers per run.
// - Separate completion interrupt per channel.
// - Completion interrupt follows terminal count flag.
// - Fixed priority, channel 0 highest.
// - Selected start factor raises CPU request.
// - RAM access one clock, peripheral three.
// - Served channel's addresses, direction, count used.
// - RAM address steps by unit size.
// - Count steps down; borrow ends the run.
// - Halfword mode ignores written count bit zero.
// - Trigger type bits plus expansion bits select.
`timescale 1ns/10ps
`default_nettype none
module dmac_top #(
    parameter int unsigned NUM_CH = 6
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [dmac_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [dmac_pkg::REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dmac_pkg::REG_DATA_W-1:0] reg_rdata,
    input wire logic [dmac_pkg::NUM_TRIG-1:0] trig_in,
    output logic cpu_dma_req,
    input wire logic cpu_dma_ack,
    output logic [dmac_pkg::MEM_ADDR_W-1:0] mem_addr,
    output logic mem_is_io,
    output logic mem_rd,
    output logic mem_wr,
    output logic mem_size16,
    output logic [dmac_pkg::REG_DATA_W-1:0] mem_wdata,
    input wire logic [dmac_pkg::REG_DATA_W-1:0] mem_rdata,
    output logic [NUM_CH-1:0] channel_done_irq,
    output logic irq
);
    import dmac_pkg::*;

    // The register map gives each channel a 16-byte window below the globals.
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
        $error("dmac_top: NUM_CH must be 1 to 8");
    end

    localparam int unsigned CH_IDX_W = 3;

    dmac_chan_if cif [NUM_CH] ();

    // Flattened views of the channel state.
    logic [NUM_CH-1:0] pend_vec;
    logic [NUM_CH-1:0] tc_vec;
    logic [7:0] ctl_arr [NUM_CH];
    logic [REG_DATA_W-1:0] io_arr [NUM_CH];
    logic [RAM_ADDR_W-1:0] ram_arr [NUM_CH];
    logic [COUNT_W-1:0] cnt_arr [NUM_CH];

    // Bus decode.
    logic [CH_IDX_W-1:0] dec_ch;
    logic [3:0] dec_ofs;
    logic dec_in_ch;

    // Global registers.
    logic [TRIG_EXP_W-1:0] trig_exp_reg;
    logic [NUM_CH-1:0] irq_status_reg;
    logic [NUM_CH-1:0] irq_enable_reg;
    logic [NUM_CH-1:0] tc_prev_reg;
    logic irq_reg;
    logic [REG_DATA_W-1:0] rdata_reg;

    // Transfer engine.
    dmac_state_e state_reg;
    logic [CH_IDX_W-1:0] cur_ch_reg;
    logic [1:0] acc_cnt_reg;
    logic [1:0] acc_len_reg;
    logic [NUM_CH-1:0] done_vec_reg;
    logic cpu_dma_req_reg;
    logic [MEM_ADDR_W-1:0] mem_addr_reg;
    logic mem_is_io_reg;
    logic mem_rd_reg;
    logic mem_wr_reg;
    logic mem_size16_reg;
    logic [REG_DATA_W-1:0] mem_wdata_reg;

    // Priority winner and its programmed fields.
    logic [CH_IDX_W-1:0] win_ch;
    logic any_pend;
    logic [MEM_ADDR_W-1:0] win_ram_addr;
    logic [MEM_ADDR_W-1:0] win_io_addr;
    logic win_ram_to_io;
    logic [MEM_ADDR_W-1:0] cur_dst_addr;
    logic cur_dst_is_io;

    assign dec_ch = reg_addr[6:4];
    assign dec_ofs = reg_addr[3:0];
    assign dec_in_ch = !reg_addr[7] && ({1'b0, dec_ch} < 4'(NUM_CH));

    // One channel block per channel, each fed its selected start factor.
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        logic sel_hit;

        assign sel_hit = dec_in_ch && (dec_ch == CH_IDX_W'(g)) && reg_wr;
        assign cif[g].wr_io = sel_hit && (dec_ofs == OFS_IO_ADDR);
        assign cif[g].wr_ram = sel_hit && (dec_ofs == OFS_RAM_ADDR);
        assign cif[g].wr_cnt = sel_hit && (dec_ofs == OFS_COUNT);
        assign cif[g].wr_ctl = sel_hit && (dec_ofs == OFS_CTRL);
        assign cif[g].wdata = reg_wdata;
        assign cif[g].trig = trig_in[{trig_exp_reg, cif[g].ctl[CTL_TTYP_HI], cif[g].ctl[CTL_TTYP_LO]}];
        assign cif[g].done = done_vec_reg[g];

        assign pend_vec[g] = cif[g].pending;
        assign tc_vec[g] = cif[g].tc;
        assign ctl_arr[g] = cif[g].ctl;
        assign io_arr[g] = cif[g].io_addr;
        assign ram_arr[g] = cif[g].ram_addr;
        assign cnt_arr[g] = cif[g].count;

        dmac_chan u_chan (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .cif(cif[g])
        );
    end

    // Fixed priority: scanning downward lets the lowest pending index win.
    always_comb begin
        win_ch = '0;
        any_pend = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (pend_vec[i]) begin
                win_ch = CH_IDX_W'(i);
                any_pend = 1'b1;
            end
        end
    end

    // The winner's addresses and direction feed the access setup.
    assign win_ram_addr = MEM_ADDR_W'(ram_arr[win_ch]);
    assign win_io_addr = io_arr[win_ch];
    assign win_ram_to_io = ctl_arr[win_ch][CTL_RAM_TO_IO];
    assign cur_dst_is_io = ctl_arr[cur_ch_reg][CTL_RAM_TO_IO];
    assign cur_dst_addr = cur_dst_is_io ? io_arr[cur_ch_reg] : MEM_ADDR_W'(ram_arr[cur_ch_reg]);

    // Transfer sequencer. The bus request is held for the whole read and
    // write pair, so the CPU cannot slip in between the two halves.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            cur_ch_reg <= '0;
            acc_cnt_reg <= '0;
            acc_len_reg <= RAM_ACC_CYC;
            done_vec_reg <= '0;
            cpu_dma_req_reg <= 1'b0;
            mem_addr_reg <= '0;
            mem_is_io_reg <= 1'b0;
            mem_rd_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            mem_size16_reg <= 1'b0;
            mem_wdata_reg <= '0;
        end else begin
            done_vec_reg <= '0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (any_pend) begin
                        cpu_dma_req_reg <= 1'b1;
                        state_reg <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    // The winner is chosen at the acknowledge, so a request
                    // that arrived during the wait can still take precedence.
                    if (cpu_dma_ack) begin
                        cur_ch_reg <= win_ch;
                        mem_size16_reg <= ctl_arr[win_ch][CTL_SIZE16];
                        mem_is_io_reg <= !win_ram_to_io;
                        mem_addr_reg <= win_ram_to_io ? win_ram_addr : win_io_addr;
                        acc_len_reg <= win_ram_to_io ? RAM_ACC_CYC : IO_ACC_CYC;
                        acc_cnt_reg <= '0;
                        mem_rd_reg <= 1'b1;
                        state_reg <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (acc_cnt_reg == acc_len_reg - 2'h1) begin
                        mem_rd_reg <= 1'b0;
                        mem_wr_reg <= 1'b1;
                        mem_wdata_reg <= mem_rdata;
                        mem_addr_reg <= cur_dst_addr;
                        mem_is_io_reg <= cur_dst_is_io;
                        acc_len_reg <= cur_dst_is_io ? IO_ACC_CYC : RAM_ACC_CYC;
                        acc_cnt_reg <= '0;
                        state_reg <= ST_WRITE;
                    end else begin
                        acc_cnt_reg <= acc_cnt_reg + 2'h1;
                    end
                end
                ST_WRITE: begin
                    if (acc_cnt_reg == acc_len_reg - 2'h1) begin
                        mem_wr_reg <= 1'b0;
                        cpu_dma_req_reg <= 1'b0;
                        done_vec_reg <= NUM_CH'(1) << cur_ch_reg;
                        state_reg <= ST_DONE;
                    end else begin
                        acc_cnt_reg <= acc_cnt_reg + 2'h1;
                    end
                end
                ST_DONE: begin
                    // One settling cycle lets the served channel drop its
                    // pending flag before the next arbitration.
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    cpu_dma_req_reg <= 1'b0;
                    mem_rd_reg <= 1'b0;
                    mem_wr_reg <= 1'b0;
                end
            endcase
        end
    end

    // Trigger expansion register.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            trig_exp_reg <= TRIG_EXP_RST;
        end else if (reg_wr && reg_addr == OFS_TRIG_EXP) begin
            trig_exp_reg <= reg_wdata[TRIG_EXP_W-1:0];
        end
    end

    // Interrupt enable register.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_enable_reg <= '0;
        end else if (reg_wr && reg_addr == OFS_IRQ_ENABLE) begin
            irq_enable_reg <= reg_wdata[NUM_CH-1:0];
        end
    end

    // Sticky status, set by the rising terminal count; a set beats a clear
    // that lands in the same cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tc_prev_reg <= '0;
            irq_status_reg <= '0;
        end else begin
            tc_prev_reg <= tc_vec;
            if (reg_wr && reg_addr == OFS_IRQ_CLEAR) begin
                irq_status_reg <= (irq_status_reg & ~reg_wdata[NUM_CH-1:0]) | (tc_vec & ~tc_prev_reg);
            end else begin
                irq_status_reg <= irq_status_reg | (tc_vec & ~tc_prev_reg);
            end
        end
    end

    // Combined interrupt, registered to keep the output glitch free.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // Read data, valid only in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= '0;
            if (reg_rd) begin
                if (dec_in_ch) begin
                    unique case (dec_ofs)
                        OFS_IO_ADDR: rdata_reg <= io_arr[dec_ch];
                        OFS_RAM_ADDR: rdata_reg <= REG_DATA_W'(ram_arr[dec_ch]);
                        OFS_COUNT: rdata_reg <= REG_DATA_W'(cnt_arr[dec_ch]);
                        OFS_CTRL: rdata_reg <= REG_DATA_W'(ctl_arr[dec_ch]);
                        default: rdata_reg <= '0;
                    endcase
                end else if (reg_addr == OFS_TRIG_EXP) begin
                    rdata_reg <= REG_DATA_W'(trig_exp_reg);
                end else if (reg_addr == OFS_IRQ_STATUS) begin
                    rdata_reg <= REG_DATA_W'(irq_status_reg);
                end else if (reg_addr == OFS_IRQ_ENABLE) begin
                    rdata_reg <= REG_DATA_W'(irq_enable_reg);
                end
            end
        end
    end

    // Each channel's completion line is its terminal count flag.
    assign channel_done_irq = tc_vec;
    assign irq = irq_reg;
    assign reg_rdata = rdata_reg;
    assign cpu_dma_req = cpu_dma_req_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_is_io = mem_is_io_reg;
    assign mem_rd = mem_rd_reg;
    assign mem_wr = mem_wr_reg;
    assign mem_size16 = mem_size16_reg;
    assign mem_wdata = mem_wdata_reg;
endmodule : dmac_top
`default_nettype wire

// file: dv/dmac_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dmac_top_sva #(
    parameter int unsigned NUM_CH = 6
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cpu_dma_req,
    input wire logic cpu_dma_ack,
    input wire logic mem_is_io,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [NUM_CH-1:0] channel_done_irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // A peripheral access spans three cycles and a RAM access one.
    sequence io_rd_s;
        mem_rd [*3] ##1 !mem_rd;
    endsequence
    sequence io_wr_s;
        mem_wr [*3] ##1 !mem_wr;
    endsequence
    sequence ram_rd_s;
        mem_rd ##1 !mem_rd;
    endsequence
    a_io_read_len: assert property ($rose(mem_rd) && mem_is_io |-> io_rd_s)
        else $error("peripheral read length wrong");
    a_ram_read_len: assert property ($rose(mem_rd) && !mem_is_io |-> ram_rd_s)
        else $error("RAM read length wrong");
    a_io_write_len: assert property ($rose(mem_wr) && mem_is_io |-> io_wr_s)
        else $error("peripheral write length wrong");
    a_read_then_write: assert property ($fell(mem_rd) |-> mem_wr && mem_is_io != $past(mem_is_io))
        else $error("write does not follow read");
    a_ack_starts_read: assert property (cpu_dma_req && cpu_dma_ack && !mem_rd && !mem_wr |=> $rose(mem_rd))
        else $error("acknowledge did not start a read");
    a_access_under_req: assert property (mem_rd || mem_wr |-> cpu_dma_req)
        else $error("access without bus request");
    a_done_after_write: assert property (|(channel_done_irq & ~$past(channel_done_irq)) |-> $past(mem_wr, 2))
        else $error("completion without a write");
    a_one_done_each: assert property ($onehot0(channel_done_irq & ~$past(channel_done_irq)))
        else $error("two completions at once");
endmodule : dmac_top_sva
bind dmac_top dmac_top_sva #(.NUM_CH(NUM_CH)) u_sva (.clk_sys(clk_sys), .resetn(resetn), .cpu_dma_req(cpu_dma_req),
    .cpu_dma_ack(cpu_dma_ack), .mem_is_io(mem_is_io), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .channel_done_irq(channel_done_irq));
`default_nettype wire

// file: dv/dmac_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmac_cpu_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cpu_dma_req,
    output logic cpu_dma_ack,
    input wire logic mem_rd,
    input wire logic [dmac_pkg::MEM_ADDR_W-1:0] mem_addr,
    output logic [dmac_pkg::REG_DATA_W-1:0] mem_rdata
);
    import dmac_pkg::*;
    logic [1:0] lag_reg;
    logic [1:0] wait_reg;
    logic taken_reg;
    logic [REG_DATA_W-1:0] last_reg;
    // The CPU ends its own work first, so the wait varies from 0 to 3 cycles per request.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cpu_dma_ack <= 1'b0;
            taken_reg <= 1'b0;
            wait_reg <= 2'h0;
            lag_reg <= 2'h0;
        end else if (!cpu_dma_req) begin
            cpu_dma_ack <= 1'b0;
            taken_reg <= 1'b0;
            wait_reg <= lag_reg;
        end else if (!taken_reg && wait_reg == 2'h0) begin
            cpu_dma_ack <= 1'b1;
            taken_reg <= 1'b1;
            lag_reg <= lag_reg + 2'h1;
        end else begin
            cpu_dma_ack <= 1'b0;
            wait_reg <= wait_reg - 2'h1;
        end
    end
    // Outside a read the bus shows the inverse of its last value, so stale data never passes.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            last_reg <= '0;
        end else begin
            last_reg <= mem_rdata;
        end
    end
    assign mem_rdata = mem_rd ? (mem_addr ^ 16'ha5c3) : ~last_reg;
endmodule : dmac_cpu_model
`default_nettype wire

// file: dv/dmac_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dmac_tb_top;
    import dmac_pkg::*;
    logic clk_sys, resetn, reg_wr, reg_rd, cpu_dma_req, cpu_dma_ack, mem_is_io, mem_rd, mem_wr, mem_size16, irq;
    logic [7:0] reg_addr, b, ctl;
    logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, rd_addr, wr_addr, wdat, d, io, ram;
    logic [31:0] trig_in;
    logic [5:0] channel_done_irq;
    logic [2:0] te;
    logic rd_q = 1'b0, wr_q = 1'b0, rd_io, wsz;
    logic [15:0] rdq[$];
    int mismatches = 0, cmp_count = 0, n_xfer = 0, cyc = 0, seed = 32'h842d, ch, i;
    int pri[3] = '{0, 1, 5};
    dmac_top #(.NUM_CH(6)) dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in), .cpu_dma_req(cpu_dma_req),
        .cpu_dma_ack(cpu_dma_ack), .mem_addr(mem_addr), .mem_is_io(mem_is_io), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_size16(mem_size16), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .channel_done_irq(channel_done_irq), .irq(irq));
    dmac_cpu_model u_cpu (.clk_sys(clk_sys), .resetn(resetn), .cpu_dma_req(cpu_dma_req),
        .cpu_dma_ack(cpu_dma_ack), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
    // The clock toggles every half period of 20 ns.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Expected unit on the write side, masked to a byte when transfers are byte wide.
    function automatic logic [15:0] unit(input logic [15:0] a, input logic s16);
        return s16 ? (a ^ 16'ha5c3) : ((a ^ 16'ha5c3) & 16'h00ff);
    endfunction : unit
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    // A write strobe lasts one cycle; the idle cycle after it keeps strobes from colliding.
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
        @(posedge clk_sys);
    endtask : rd
    // Pulse the start factors and wait a bounded time for n transfers.
    task automatic fire(input logic [31:0] m, input int n);
        int k;
        k = n_xfer + n;
        trig_in <= m;
        @(posedge clk_sys);
        trig_in <= '0;
        repeat (40 * n) begin
            if (n_xfer != k) @(posedge clk_sys);
        end
        repeat (12) @(posedge clk_sys);
        check(16'(n_xfer), 16'(k));
    endtask : fire
    // Record each access as it starts; the cycle ceiling cuts a hang short.
    always @(posedge clk_sys) begin
        rd_q <= mem_rd;
        wr_q <= mem_wr;
        cyc <= cyc + 1;
        if (mem_rd && !rd_q) begin
            rd_addr <= mem_addr;
            rd_io <= mem_is_io;
            rdq.push_back(mem_addr);
        end
        if (mem_wr && !wr_q) begin
            wr_addr <= mem_addr;
            wdat <= mem_wdata;
            wsz <= mem_size16;
            n_xfer <= n_xfer + 1;
        end
        if (cyc == 30000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        resetn = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        trig_in = '0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        for (ch = 0; ch < 6; ch++) begin
            rd(8'(ch * 16 + 12));
            check(d, 16'h0000);
        end
        wr(8'hf0, 16'hffff);
        rd(8'hf0);
        check(d, 16'h0000);
        rd(OFS_TRIG_EXP);
        check(d, 16'h0000);
        $display("reset values done");
        // Each channel moves one unit with a random start factor, size, direction and addresses.
        for (ch = 0; ch < 6; ch++) begin
            b = 8'(ch * 16);
            io = 16'($random(seed)) & IO_ADDR_MASK;
            ram = 16'($random(seed)) & 16'h3ffe;
            te = 3'($random(seed));
            ctl = (8'($random(seed)) & 8'h3e) | 8'h01;
            wr(OFS_TRIG_EXP, {13'h0, te});
            wr(b, io);
            wr(b + 8'h04, ram);
            wr(b + 8'h08, 16'h0000);
            wr(OFS_IRQ_ENABLE, 16'(1 << ch));
            wr(b + 8'h0c, {8'h00, ctl});
            fire(32'h1 << {te, ctl[4:3]}, 1);
            check(rd_addr, ctl[5] ? ram : io);
            check(wr_addr, ctl[5] ? io : ram);
            check(16'(rd_io), 16'(!ctl[5]));
            check(16'(wsz), 16'(ctl[1]));
            check(wdat & (ctl[1] ? 16'hffff : 16'h00ff), unit(ctl[5] ? ram : io, ctl[1]));
            check(16'(channel_done_irq), 16'((2 << ch) - 1));
            check(16'(irq), 16'h0001);
            rd(b + 8'h0c);
            check(d, {8'h00, (ctl & 8'h3e) | 8'h80});
            rd(b + 8'h04);
            check(d, ctl[2] ? ram : ((ram + (ctl[1] ? 16'h2 : 16'h1)) & 16'h3fff));
            rd(OFS_IRQ_STATUS);
            check(d, 16'(1 << ch));
            wr(OFS_IRQ_CLEAR, 16'(1 << ch));
            rd(OFS_IRQ_STATUS);
            check(d, 16'h0000);
            check(16'(irq), 16'h0000);
        end
        $display("single transfers done");
        // Channels now stand disabled, so every start factor must be ignored.
        fire(32'hffffffff, 0);
        // One shared start factor makes three channels request at once.
        wr(OFS_TRIG_EXP, 16'h0000);
        foreach (pri[i]) begin
            wr(8'(pri[i] * 16), 16'h0100 + 16'(pri[i] * 2));
            wr(8'(pri[i] * 16 + 8), 16'h0000);
            wr(8'(pri[i] * 16 + 12), 16'h0001);
        end
        rdq.delete();
        fire(32'h1, 3);
        foreach (pri[i]) check(rdq[i], 16'h0100 + 16'(pri[i] * 2));
        $display("priority done");
        // A halfword count drops its low bit; the control write comes first.
        wr(8'h3c, 16'h0002);
        wr(8'h38, 16'h0003);
        rd(8'h38);
        check(d, 16'h0002);
        // A full byte run of 256 units that wraps the RAM address.
        wr(8'h44, 16'h3f80);
        wr(8'h48, 16'h00ff);
        wr(8'h4c, 16'h0009);
        for (i = 0; i < 256; i++) begin
            fire(32'h2, 1);
            check(16'(channel_done_irq[4]), 16'(i == 255));
        end
        rd(8'h44);
        check(d, 16'h0080);
        $display("long run done");
        end_sim();
    end
endmodule : dmac_tb_top
`default_nettype wire
